//--- ppmg_gpio_top.sv
// port latches, type registers, second multiplexer register and pad control
// assumes sfr strobes are single-cycle and pads are synchronous to mclk
`include "ppmg_params.svh"
module ppmg_gpio_top
  import ppmg_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic sfrRmw,
  input wire logic [7:0] sfrBitAddr,
  input wire logic sfrBitWrEn,
  input wire logic sfrBitWrData,
  input wire logic sfrBitRdEn,
  output logic [7:0] sfrRdData,
  output logic sfrRdBit,
  output logic sfrRdValid,
  input wire logic [31:0] padIn,
  output logic [31:0] padOut,
  output logic [31:0] padOeN,
  output logic [31:0] padPullupEn,
  input wire logic [4:0] cmpOut,
  output logic timer0In,
  output logic timer1In,
  output logic eciIn
);
  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] portSel(input logic [7:0] a);
    // bit 2 flags a hit, bits 1:0 give the port
    unique case (a)
      `PPMG_ADDR_PORT0: portSel = 3'h4;
      `PPMG_ADDR_PORT1: portSel = 3'h5;
      `PPMG_ADDR_PORT2: portSel = 3'h6;
      `PPMG_ADDR_PORT3: portSel = 3'h7;
      default: portSel = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] typeSel(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    typeSel = (a >= b && d < 8'h04) ? {1'b1, d[1:0]} : 3'h0;
  endfunction

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  ppmg_port_arr_t latch_ff, nxt_latch;
  ppmg_port_arr_t oType_ff, nxt_oType;
  ppmg_port_arr_t iType_ff, nxt_iType;
  ppmg_byte_t mux2_ff, nxt_mux2;
  logic [7:0] rdData_ff, nxt_rdData;
  logic rdBit_ff, nxt_rdBit, rdValid_ff, nxt_rdValid;
  ppmg_port_arr_t pinRead;
  logic [2:0] wSel, rSel, bSel, wOt, wIt, rOt, rIt;

  always_comb
  begin
    wSel = portSel(sfrAddr);
    rSel = portSel(sfrAddr);
    bSel = portSel({sfrBitAddr[`PPMG_BASE_HI:`PPMG_BASE_LO], 3'h0});
    wOt = typeSel(sfrAddr, `PPMG_ADDR_OTYPE0);
    wIt = typeSel(sfrAddr, `PPMG_ADDR_ITYPE0);
    rOt = wOt;
    rIt = wIt;
    for (int p = 0; p < PPMG_NPORT; p++)
    begin
      for (int b = 0; b < PPMG_PW; b++)
      begin
        // analog pins have their receiver off and read a fixed level
        pinRead[p][b] = iType_ff[p][b] ? padIn[p*PPMG_PW+b] : `PPMG_ANALOG_READ; // see RL4
      end
    end
    nxt_latch = latch_ff;
    nxt_oType = oType_ff;
    nxt_iType = iType_ff;
    nxt_mux2 = mux2_ff;
    if (sfrWrEn)
    begin
      if (wSel[2])
        nxt_latch[wSel[1:0]] = sfrWrData; // see RL3
      if (wOt[2])
        nxt_oType[wOt[1:0]] = sfrWrData;
      if (wIt[2])
        nxt_iType[wIt[1:0]] = sfrWrData; // see RL10
      if (sfrAddr == `PPMG_ADDR_MUX2)
        nxt_mux2 = sfrWrData; // see RL6
    end
    // a single-bit store touches one latch bit only; the other seven bits keep their value
    if (sfrBitWrEn && bSel[2])
      nxt_latch[bSel[1:0]][sfrBitAddr[`PPMG_BITSEL_HI:0]] = sfrBitWrData; // see RL2
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  always_comb
  begin
    nxt_rdValid = sfrRdEn || sfrBitRdEn;
    nxt_rdData = `PPMG_RD_UNMAPPED;
    nxt_rdBit = 1'b0;
    if (sfrRdEn)
    begin
      if (rSel[2])
        nxt_rdData = sfrRmw ? latch_ff[rSel[1:0]] : pinRead[rSel[1:0]]; // see RL4, RL5
      else if (rOt[2])
        nxt_rdData = oType_ff[rOt[1:0]];
      else if (rIt[2])
        nxt_rdData = iType_ff[rIt[1:0]];
      else if (sfrAddr == `PPMG_ADDR_MUX2)
        nxt_rdData = mux2_ff;
    end
    if (sfrBitRdEn && bSel[2])
      nxt_rdBit = sfrRmw ? latch_ff[bSel[1:0]][sfrBitAddr[`PPMG_BITSEL_HI:0]]
                : pinRead[bSel[1:0]][sfrBitAddr[`PPMG_BITSEL_HI:0]]; // see RL5
  end

  // ---------------------------------------------------------------------------
  // pad control
  // ---------------------------------------------------------------------------
  ppmg_byte_t ovrDrive, ovrVal, ovrInput;
  logic tm0Pin, tm1Pin, eciPinLvl;
  logic [31:0] nxt_padOut, nxt_padOeN, nxt_padPullupEn;
  logic [31:0] padOut_ff, padOeN_ff, padPullupEn_ff;
  logic tm0_ff, tm1_ff, eci_ff;

  ppmg_route uRoute (
    .muxCfg(mux2_ff),
    .pinLevel(padIn[7:0]),
    .cmpOut(cmpOut),
    .ovrDrive(ovrDrive),
    .ovrVal(ovrVal),
    .ovrInput(ovrInput),
    .timer0Pin(tm0Pin),
    .timer1Pin(tm1Pin),
    .eciPin(eciPinLvl)
  );

  always_comb
  begin
    logic v;
    logic drv;
    int k;
    v = 1'b0;
    drv = 1'b0;
    k = 0;
    for (int p = 0; p < PPMG_NPORT; p++)
    begin
      for (int b = 0; b < PPMG_PW; b++)
      begin
        k = p * PPMG_PW + b;
        // unassigned digital pins follow the latch
        v = (p == 0 && ovrDrive[b]) ? ovrVal[b] : latch_ff[p][b]; // see RL1
        // drivers stay off until the multiplexer is on; open-drain only pulls low
        drv = mux2_ff[`PPMG_MUXEN_BIT] && iType_ff[p][b] && !(p == 0 && ovrInput[b])
              && (oType_ff[p][b] || !v); // see RL8, RL9
        nxt_padOut[k] = v;
        nxt_padOeN[k] = !drv;
        nxt_padPullupEn[k] = !mux2_ff[`PPMG_WPUD_BIT] && iType_ff[p][b]
                             && !oType_ff[p][b] && !drv; // see RL7
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < PPMG_NPORT; p++)
      begin
        latch_ff[p] <= `PPMG_RST_LATCH;
        oType_ff[p] <= `PPMG_RST_OTYPE;
        iType_ff[p] <= `PPMG_RST_ITYPE; // see RL10
      end
      mux2_ff <= `PPMG_RST_MUX2;
      rdData_ff <= '0;
      rdBit_ff <= 1'b0;
      rdValid_ff <= 1'b0;
      padOut_ff <= '1;
      padOeN_ff <= '1;
      padPullupEn_ff <= '0;
      tm0_ff <= 1'b1;
      tm1_ff <= 1'b1;
      eci_ff <= 1'b1;
    end
    else
    begin
      latch_ff <= nxt_latch;
      oType_ff <= nxt_oType;
      iType_ff <= nxt_iType;
      mux2_ff <= nxt_mux2;
      rdData_ff <= nxt_rdData;
      rdBit_ff <= nxt_rdBit;
      rdValid_ff <= nxt_rdValid;
      padOut_ff <= nxt_padOut;
      padOeN_ff <= nxt_padOeN;
      padPullupEn_ff <= nxt_padPullupEn;
      tm0_ff <= tm0Pin;
      tm1_ff <= tm1Pin;
      eci_ff <= eciPinLvl;
    end
  end

  assign sfrRdData = rdData_ff;
  assign sfrRdBit = rdBit_ff;
  assign sfrRdValid = rdValid_ff;
  assign padOut = padOut_ff;
  assign padOeN = padOeN_ff;
  assign padPullupEn = padPullupEn_ff;
  assign timer0In = tm0_ff;
  assign timer1In = tm1_ff;
  assign eciIn = eci_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  latch_write_a: assert property ((sfrWrEn && sfrAddr == `PPMG_ADDR_PORT2 && !sfrBitWrEn) // see RL3
    |=> latch_ff[2] == $past(sfrWrData)
    ##1 (sfrWrEn || sfrBitWrEn || latch_ff[2] == $past(latch_ff[2])))
    else $error("port latch did not capture or hold write");
  bit_write_a: assert property ((sfrBitWrEn && sfrBitAddr == 8'h93 && !sfrWrEn) // see RL2
    |=> latch_ff[1][3] == $past(sfrBitWrData) && latch_ff[1][2:0] == $past(latch_ff[1][2:0]))
    else $error("bit store wrong");
  pin_read_a: assert property ((sfrRdEn && !sfrRmw && sfrAddr == `PPMG_ADDR_PORT0 // see RL4
    && &iType_ff[0]) |=> sfrRdValid && sfrRdData == $past(padIn[7:0]))
    else $error("port read not pin level");
  rmw_read_a: assert property ((sfrRdEn && sfrRmw && sfrAddr == `PPMG_ADDR_PORT3) // see RL5
    |=> sfrRdData == $past(latch_ff[3]))
    else $error("rmw read not latch");
  timer_route_a: assert property ((mux2_ff[`PPMG_MUXEN_BIT] && mux2_ff[`PPMG_T0E_BIT]) // see RL6
    |=> timer0In == $past(padIn[`PPMG_T0_PIN]) && padOeN[`PPMG_T0_PIN])
    else $error("timer 0 route wrong");
  cmp_route_a: assert property ((mux2_ff[`PPMG_MUXEN_BIT] && mux2_ff[2:0] == 3'h3 // see RL6
    && iType_ff[0][2] && oType_ff[0][2]) |=> padOut[2] == $past(cmpOut[2]) && !padOeN[2]
    && padOut[3] == $past(latch_ff[0][3]))
    else $error("compare route wrong");
  pullup_on_a: assert property ((!mux2_ff[`PPMG_WPUD_BIT] && iType_ff[1][4] // see RL7
    && !oType_ff[1][4] && !mux2_ff[`PPMG_MUXEN_BIT]) |=> padPullupEn[12])
    else $error("weak pull-up missing");
  mux_off_a: assert property (!mux2_ff[`PPMG_MUXEN_BIT] // see RL8, RL9
    |=> &padOeN && timer1In && eciIn)
    else $error("pin driven with multiplexer off");
  reset_type_a: assert property ($past(!nrst) // see RL10
    |-> &iType_ff[0] && &iType_ff[3] && mux2_ff == `PPMG_RST_MUX2)
    else $error("reset values wrong");
  gpio_drive_a: assert property ((mux2_ff[`PPMG_MUXEN_BIT] && oType_ff[1][0] // see RL1
    && iType_ff[1][0]) |=> !padOeN[8] && padOut[8] == $past(latch_ff[1][0]))
    else $error("gpio push-pull not following latch");
endmodule

//--- ppmg_gpio_top_test.sv
// self-checking bench for the port latches, type registers and multiplexer
// assumes the pin model closes the loop from pad outputs to pad inputs
module ppmg_gpio_top_test;
  import ppmg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrBitAddr = 8'h00;
  logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, sfrRmw = 1'b0;
  logic sfrBitWrEn = 1'b0, sfrBitWrData = 1'b0, sfrBitRdEn = 1'b0;
  logic [7:0] sfrRdData;
  logic sfrRdBit, sfrRdValid, timer0In, timer1In, eciIn;
  logic [31:0] padIn, padOut, padOeN, padPullupEn;
  logic [31:0] extEn = 32'h0, extVal = 32'h0;
  logic [4:0] cmpOut = 5'h00;
  logic [7:0] rv;
  logic rb;
  int mismatches = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  ppmg_gpio_top uut (.mclk(mclk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw), .sfrBitAddr(sfrBitAddr),
    .sfrBitWrEn(sfrBitWrEn), .sfrBitWrData(sfrBitWrData), .sfrBitRdEn(sfrBitRdEn),
    .sfrRdData(sfrRdData), .sfrRdBit(sfrRdBit), .sfrRdValid(sfrRdValid), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .padPullupEn(padPullupEn), .cmpOut(cmpOut),
    .timer0In(timer0In), .timer1In(timer1In), .eciIn(eciIn));
  ppmg_pin_model pins (.mclk(mclk), .padOut(padOut), .padOeN(padOeN),
    .padPullupEn(padPullupEn), .extEn(extEn), .extVal(extVal), .padIn(padIn));
  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge mclk);
    sfrWrEn <= 1'b0;
  endtask
  task automatic wrb(input logic [7:0] a, input logic d);
    @(posedge mclk);
    sfrBitAddr <= a;
    sfrBitWrData <= d;
    sfrBitWrEn <= 1'b1;
    @(posedge mclk);
    sfrBitWrEn <= 1'b0;
  endtask
  // one task serves byte and bit reads so the valid pulse is checked alike
  task automatic rd(input logic [7:0] a, input logic m, input logic isBit);
    @(posedge mclk);
    sfrAddr <= a;
    sfrBitAddr <= a;
    sfrRmw <= m;
    sfrRdEn <= !isBit;
    sfrBitRdEn <= isBit;
    @(posedge mclk);
    sfrRdEn <= 1'b0;
    sfrBitRdEn <= 1'b0;
    #1;
    chk("rdValid", 32'h1, {31'h0, sfrRdValid});
    rv = sfrRdData;
    rb = sfrRdBit;
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    chk("oeN rst", 32'hffff_ffff, padOeN);
    chk("pullup rst", 32'hffff_ffff, padPullupEn);
    chk("t0 rst", 32'h1, {31'h0, timer0In});
    rd(8'h80, 1'b1, 1'b0);
    chk("p0 rst", 32'hff, {24'h0, rv});
    rd(8'ha4, 1'b0, 1'b0);
    chk("otype rst", 32'h00, {24'h0, rv});
    rd(8'he2, 1'b0, 1'b0);
    chk("mux2 rst", 32'h00, {24'h0, rv});
    rd(8'hf1, 1'b0, 1'b0);
    chk("itype rst", 32'hff, {24'h0, rv});
    wr(8'h81, 8'h33);
    rd(8'h81, 1'b0, 1'b0);
    chk("unmapped", 32'h00, {24'h0, rv});
    // latch written while the multiplexer is off: no driver may turn on
    wr(8'h80, 8'h5a);
    wr(8'ha4, 8'h0f);
    extEn <= 32'h0000_00ff;
    extVal <= 32'h0000_00c3;
    settle();
    chk("oeN muxoff", 32'hffff_ffff, padOeN);
    rd(8'h80, 1'b0, 1'b0);
    chk("p0 pins", 32'hc3, {24'h0, rv});
    rd(8'h80, 1'b1, 1'b0);
    chk("p0 rmw", 32'h5a, {24'h0, rv});
    extEn <= 32'h0;
    wr(8'he2, 8'h40);
    settle();
    chk("oeN p0", 32'h50, {24'h0, padOeN[7:0]});
    chk("out p0", 32'h5a, {24'h0, padOut[7:0]});
    chk("pullup p0", 32'h50, {24'h0, padPullupEn[7:0]});
    rd(8'h80, 1'b0, 1'b0);
    chk("p0 loop", 32'h5a, {24'h0, rv});
    wr(8'he2, 8'hc0);
    settle();
    chk("pullup off", 32'h0, padPullupEn);
    wr(8'ha5, 8'h01);
    // ports one to three by byte and by bit
    for (int p = 1; p < 4; p++)
    begin
      wr(8'h80 + 8'(p * 16), 8'(8'ha5 ^ p));
      wrb(8'h80 + 8'(p * 16) + 8'd3, 1'b0);
      rd(8'h80 + 8'(p * 16), 1'b1, 1'b0);
      chk("port byte", 32'(8'(8'ha5 ^ p) & 8'hf7), {24'h0, rv});
      rd(8'h80 + 8'(p * 16) + 8'd2, 1'b1, 1'b1);
      chk("port bit", 32'(((8'ha5 ^ p) >> 2) & 1), {31'h0, rb});
    end
    // push-pull pin on port 1 must drive a one, which open-drain never would
    wrb(8'h90, 1'b1);
    settle();
    chk("p1 push-pull", 32'h1, {30'h0, padOeN[8], padOut[8]});
    // compare outputs on port 0 for every count code, plus timer routes
    wr(8'ha4, 8'h1f);
    wr(8'h80, 8'hff);
    cmpOut <= 5'h0a;
    extEn <= 32'h0000_00e0;
    extVal <= 32'h0000_0040;
    for (int n = 0; n < 8; n++)
    begin
      int k;
      logic [7:0] ev;
      // codes six and seven route the same five outputs as five
      k = (n > 5) ? 5 : n;
      ev = 8'((8'hff << k) | (8'h0a & ~(8'hff << k)));
      wr(8'he2, 8'h78 | 8'(n));
      settle();
      chk("cmp route", {24'h0, ev}, {24'h0, padOut[7:0]});
    end
    chk("timers", 32'h2, {29'h0, timer0In, timer1In, eciIn});
    // analog input pin reads one and loses its pull-up
    extEn <= 32'h1;
    extVal <= 32'h0;
    wr(8'he2, 8'h40);
    wr(8'hf1, 8'hfe);
    settle();
    chk("analog pu", 32'h0, {31'h0, padPullupEn[0]});
    rd(8'h80, 1'b0, 1'b0);
    chk("analog rd", 32'h1, {31'h0, rv[0]});
    test_done();
  end
  initial
  begin
    #(3000 * 8);
    mismatches++;
    test_done();
  end
endmodule

//--- ppmg_params.svh
// constants for the port pin multiplexer and general-purpose port block
// assumes an 8-bit special function register space and four 8-bit ports
// ---------------------------------------------------------------------------
// Overview of operation
// RL1: a pin neither given to a peripheral by the multiplexer nor analog is plain port i/o.
// RL2: each of the four ports has its own register, reachable both as a byte and as single bits.
// RL3: a port write goes into an output latch that holds the pin value until the next write.
// RL4: an ordinary port read returns the pin levels, even for pins given to a peripheral. The code returns one for analog pins instead.
// RL5: read-modify-write accesses, single-bit moves included, read the latch, not the pins.
// RL6: mux register two routes the timer and counter clock inputs and up to five compare outputs.
// RL7: with pull-up disable clear, open-drain pins have weak pull-ups on unless driving low. The code also keeps them off on analog pins.
// RL8: the multiplexer acts only once its enable bit is set; until then every pin is an input.
// RL9: all output drivers stay off while the multiplexer enable bit is clear.
// RL10: input-type bit one selects digital input, zero analog; all pins reset to digital.
// ---------------------------------------------------------------------------
`ifndef PPMG_PARAMS_SVH
`define PPMG_PARAMS_SVH

// ---------------------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------------------
`define PPMG_ADDR_PORT0 8'h80
`define PPMG_ADDR_PORT1 8'h90
`define PPMG_ADDR_PORT2 8'ha0
`define PPMG_ADDR_PORT3 8'hb0
`define PPMG_ADDR_OTYPE0 8'ha4
`define PPMG_ADDR_OTYPE1 8'ha5
`define PPMG_ADDR_OTYPE2 8'ha6
`define PPMG_ADDR_OTYPE3 8'ha7
`define PPMG_ADDR_ITYPE0 8'hf1
`define PPMG_ADDR_ITYPE1 8'hf2
`define PPMG_ADDR_ITYPE2 8'hf3
`define PPMG_ADDR_ITYPE3 8'hf4
`define PPMG_ADDR_MUX2 8'he2

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define PPMG_RST_LATCH 8'hff
`define PPMG_RST_OTYPE 8'h00
`define PPMG_RST_ITYPE 8'hff
`define PPMG_RST_MUX2 8'h00
`define PPMG_RD_UNMAPPED 8'h00
`define PPMG_ANALOG_READ 1'b1

// ---------------------------------------------------------------------------
// second multiplexer register fields and routed pins of port 0
// ---------------------------------------------------------------------------
`define PPMG_WPUD_BIT 7
`define PPMG_MUXEN_BIT 6
`define PPMG_T1E_BIT 5
`define PPMG_T0E_BIT 4
`define PPMG_COUNTER_ARRAY_CLOCK_INPUT_ROUTE_ENABLE_BIT 3
`define PPMG_CNT_HI 2
`define PPMG_CNT_LO 0
`define PPMG_CNT_MAX 3'h5
`define PPMG_T0_PIN 5
`define PPMG_T1_PIN 6
`define PPMG_ECI_PIN 7
`define PPMG_BITSEL_HI 2
`define PPMG_BASE_HI 7
`define PPMG_BASE_LO 3

`endif

//--- ppmg_pin_model.sv
// package pins and peripheral sources around the port block
// assumes pads are synchronous to mclk; the bench steers the outside drive
module ppmg_pin_model
  import ppmg_pkg::*;
(
  input wire logic mclk,
  input wire logic [31:0] padOut,
  input wire logic [31:0] padOeN,
  input wire logic [31:0] padPullupEn,
  input wire logic [31:0] extEn,
  input wire logic [31:0] extVal,
  output logic [31:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] floatPat;
  initial floatPat = 32'h5555_5555;
  // a floating pin must not settle to a value the simulator picks
  always @(posedge mclk) floatPat <= ~floatPat;
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      padIn[i] = !padOeN[i] ? padOut[i] : extEn[i] ? extVal[i] :
                 padPullupEn[i] ? 1'b1 : floatPat[i];
  end
endmodule

//--- ppmg_pkg.sv
// types shared by the port pin multiplexer block
// assumes ppmg_params.svh is on the include path
package ppmg_pkg;
  localparam int PPMG_NPORT = 4;
  localparam int PPMG_PW = 8;
  typedef logic [PPMG_PW-1:0] ppmg_byte_t;
  typedef ppmg_byte_t [PPMG_NPORT-1:0] ppmg_port_arr_t;
  typedef logic [2:0] ppmg_cnt_t;
endpackage

//--- ppmg_route.sv
// routing of peripheral signals onto port 0 pins
// assumes pin levels already synchronous to the clock; purely combinational
`include "ppmg_params.svh"
module ppmg_route
  import ppmg_pkg::*;
(
  input wire ppmg_byte_t muxCfg,
  input wire ppmg_byte_t pinLevel,
  input wire logic [4:0] cmpOut,
  output ppmg_byte_t ovrDrive,
  output ppmg_byte_t ovrVal,
  output ppmg_byte_t ovrInput,
  output logic timer0Pin,
  output logic timer1Pin,
  output logic eciPin
);
  logic muxEn;
  ppmg_cnt_t cnt;

  always_comb
  begin
    muxEn = muxCfg[`PPMG_MUXEN_BIT];
    // codes above five act as five: there are only five compare outputs
    cnt = (muxCfg[`PPMG_CNT_HI:`PPMG_CNT_LO] > `PPMG_CNT_MAX) ? `PPMG_CNT_MAX
          : muxCfg[`PPMG_CNT_HI:`PPMG_CNT_LO];
    ovrDrive = '0;
    ovrVal = '0;
    ovrInput = '0;
    for (int i = 0; i < 5; i++)
    begin
      if (muxEn && (cnt > 3'(i)))
      begin
        ovrDrive[i] = 1'b1; // see RL6
        ovrVal[i] = cmpOut[i];
      end
    end
    // routed inputs hold their pin undriven; idle level is high (see RL8)
    ovrInput[`PPMG_T0_PIN] = muxEn && muxCfg[`PPMG_T0E_BIT];
    ovrInput[`PPMG_T1_PIN] = muxEn && muxCfg[`PPMG_T1E_BIT];
    ovrInput[`PPMG_ECI_PIN] = muxEn && muxCfg[`PPMG_COUNTER_ARRAY_CLOCK_INPUT_ROUTE_ENABLE_BIT];
    timer0Pin = ovrInput[`PPMG_T0_PIN] ? pinLevel[`PPMG_T0_PIN] : 1'b1; // see RL6
    timer1Pin = ovrInput[`PPMG_T1_PIN] ? pinLevel[`PPMG_T1_PIN] : 1'b1;
    eciPin = ovrInput[`PPMG_ECI_PIN] ? pinLevel[`PPMG_ECI_PIN] : 1'b1;
  end
endmodule
